/* hw/frr_fault_response.sv */
// Input over-voltage fault limit, response setting and retry sequencer
module frr_fault_response (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	// Command port
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_cmd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	output logic             reg_hit_o,
	// Measurement and timebase
	input  wire logic [15:0] vin_meas_i,
	input  wire logic        time_unit_tick_i,
	// Clearing and on/off control
	input  wire logic        clear_faults_i,
	input  wire logic        status_clear_i,
	input  wire logic        ctrl_pin_i,
	input  wire logic        op_on_i,
	input  wire logic        other_fault_off_i,
	// Status and power stage control
	output logic             output_en_o,
	output logic             vin_ov_status_o,
	output logic             retry_latched_o,
	output logic      [2:0]  attempt_count_o
);
	logic [15:0]            thresh;
	logic [7:0]             action;
	logic                   ctrl_meta;
	logic                   ctrl_sync;
	logic                   ov_det;
	logic                   on_cmd;
	logic                   timer_start;
	logic                   timer_done;
	logic [1:0]             act_sel;
	logic [2:0]             retry_sel;
	logic [2:0]             delay_sel;
	logic                   retries_left;
	logic                   clear_any;
	logic                   next_out_en;
	frr_pkg::frr_state_t    state;
	frr_pkg::frr_state_t    next_state;
	logic [2:0]             next_attempts;

	// Linear value to signed fixed point with a fixed fraction
	function automatic logic signed [frr_pkg::FIX_W-1:0] lin_to_fix(
		input logic [15:0] lin
	);
		logic signed [frr_pkg::FIX_W-1:0] mant;
		logic signed [4:0]                exp5;
		logic        [5:0]                sh;
		mant = frr_pkg::FIX_W'(signed'(lin[frr_pkg::LIN_MANT_MSB:0]));
		exp5 = signed'(lin[15:frr_pkg::LIN_EXP_LSB]);
		sh   = 6'(exp5 + 6'(frr_pkg::FIX_FRAC));
		lin_to_fix = mant <<< sh;
	endfunction

	assign act_sel   = action[frr_pkg::ACT_MSB:frr_pkg::ACT_LSB];     // [RULE12]
	assign retry_sel = action[frr_pkg::RETRY_MSB:frr_pkg::RETRY_LSB]; // [RULE12]
	assign delay_sel = action[frr_pkg::DELAY_MSB:frr_pkg::DELAY_LSB]; // [RULE12]
	assign on_cmd    = ctrl_sync && op_on_i;
	assign clear_any = clear_faults_i || status_clear_i;
	assign retries_left = (retry_sel == frr_pkg::RETRY_FOREVER) ||
		(attempt_count_o < retry_sel);                       // [RULE6] [RULE8]

	// Control pin synchroniser
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_meta <= 1'b0;
			ctrl_sync <= 1'b0;
		end else begin
			ctrl_meta <= ctrl_pin_i;
			ctrl_sync <= ctrl_meta;
		end
	end

	// Register writes
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			thresh <= frr_pkg::THRESH_RESET;
			action <= frr_pkg::ACTION_RESET;
		end else if (reg_wr_i) begin
			if (reg_cmd_i == frr_pkg::CMD_VIN_OV_THRESH) begin
				thresh <= reg_wdata_i; // [RULE11]
			end
			if (reg_cmd_i == frr_pkg::CMD_VIN_OV_ACTION) begin
				action <= reg_wdata_i[7:0]; // [RULE12]
			end
		end
	end

	// Register reads, answered one cycle later
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 16'h0000;
			reg_hit_o   <= 1'b0;
		end else if (reg_rd_i) begin
			case (reg_cmd_i)
				frr_pkg::CMD_VIN_OV_THRESH: begin
					reg_rdata_o <= thresh;
					reg_hit_o   <= 1'b1;
				end
				frr_pkg::CMD_VIN_OV_ACTION: begin
					reg_rdata_o <= {8'h00, action};
					reg_hit_o   <= 1'b1;
				end
				default: begin
					reg_rdata_o <= 16'h0000;
					reg_hit_o   <= 1'b0;
				end
			endcase
		end
	end

	// Over-voltage compare in volts
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ov_det <= 1'b0;
		end else begin
			ov_det <= lin_to_fix(vin_meas_i) > lin_to_fix(thresh); // [RULE13]
		end
	end

	// Sticky status, a new fault wins over a clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vin_ov_status_o <= 1'b0;
		end else if (ov_det) begin
			vin_ov_status_o <= 1'b1; // [RULE13]
		end else if (clear_any) begin
			vin_ov_status_o <= 1'b0;
		end
	end

	frr_delay_timer #(
		.CNT_W(frr_pkg::DELAY_CNT_W)
	) u_delay_timer (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.start_i   (timer_start),
		.tick_i    (time_unit_tick_i),
		.sel_i     (delay_sel),
		.done_o    (timer_done)
	);

	// Response sequencer
	always_comb begin
		next_state    = state;
		next_attempts = attempt_count_o;
		timer_start   = 1'b0;
		case (state)
			frr_pkg::FRR_RUN: begin
				if (ov_det) begin
					case (act_sel)
						frr_pkg::ACT_IGNORE: begin
							next_state = frr_pkg::FRR_RUN; // [RULE1]
						end
						frr_pkg::ACT_RUN_ON: begin
							next_state  = frr_pkg::FRR_RUN_ON; // [RULE2]
							timer_start = 1'b1; // [RULE10]
						end
						frr_pkg::ACT_DISABLE_RETRY: begin
							if (retry_sel == frr_pkg::RETRY_NONE) begin
								next_state = frr_pkg::FRR_LATCH; // [RULE5]
							end else begin
								next_state  = frr_pkg::FRR_WAIT; // [RULE3]
								timer_start = 1'b1;
							end
						end
						default: begin
							next_state = frr_pkg::FRR_LATCH; // [RULE4]
						end
					endcase
				end
			end
			frr_pkg::FRR_RUN_ON: begin
				if (timer_done) begin
					if (!ov_det) begin
						next_state = frr_pkg::FRR_RUN;
					end else if (retry_sel == frr_pkg::RETRY_NONE) begin
						next_state = frr_pkg::FRR_LATCH; // [RULE2] [RULE5]
					end else begin
						next_state  = frr_pkg::FRR_WAIT; // [RULE2]
						timer_start = 1'b1; // [RULE10]
					end
				end
			end
			frr_pkg::FRR_WAIT: begin
				if (timer_done) begin
					if (retries_left) begin
						next_state  = frr_pkg::FRR_TRY; // [RULE6] [RULE8]
						timer_start = 1'b1; // [RULE7]
						if (retry_sel != frr_pkg::RETRY_FOREVER) begin
							next_attempts = attempt_count_o + 3'h1;
						end
					end else begin
						next_state = frr_pkg::FRR_LATCH; // [RULE6]
					end
				end
			end
			frr_pkg::FRR_TRY: begin
				// Timer keeps running so the next start stays on pace
				if (ov_det) begin
					next_state = frr_pkg::FRR_WAIT; // [RULE7]
				end else if (timer_done) begin
					next_state    = frr_pkg::FRR_RUN;
					next_attempts = 3'h0;
				end
			end
			frr_pkg::FRR_LATCH: begin
				if (clear_any) begin
					next_state    = frr_pkg::FRR_RUN; // [RULE4]
					next_attempts = 3'h0;
				end
			end
			default: begin
				next_state = frr_pkg::FRR_LATCH;
			end
		endcase
		if (!on_cmd) begin
			next_state    = frr_pkg::FRR_RUN; // [RULE4] [RULE8]
			next_attempts = 3'h0;
		end else if (other_fault_off_i) begin
			next_state = frr_pkg::FRR_LATCH; // [RULE8]
		end
	end

	assign next_out_en = on_cmd && ((next_state == frr_pkg::FRR_RUN) ||
		(next_state == frr_pkg::FRR_RUN_ON) ||
		(next_state == frr_pkg::FRR_TRY)); // [RULE1] [RULE3]

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state           <= frr_pkg::FRR_RUN;
			attempt_count_o <= 3'h0;
			output_en_o     <= 1'b0;
			retry_latched_o <= 1'b0;
		end else begin
			state           <= next_state;
			attempt_count_o <= next_attempts;
			output_en_o     <= next_out_en;
			retry_latched_o <= next_state == frr_pkg::FRR_LATCH;
		end
	end
endmodule // frr_fault_response

/* hw/frr_pkg.sv */
// Package: register map, field layout and constants of the fault response
// Functional notes
// RULE1: Action 00 keeps the output regulating through the fault.
// RULE2: Action 01 runs for the delay, then follows retries if fault remains.
// RULE3: Action 10 disables output at once, then follows the retry setting.
// RULE4: Action 11 stays off until a clear, reset or off-then-on command.
// RULE5: Retry 000 makes no restart; output stays off until cleared.
// RULE6: Retry 001 to 110 restarts that many times, then stays off.
// RULE7: Restart attempts start one delay count of time units apart.
// RULE8: Retry 111 restarts without limit until off or another fault.
// RULE9: Delay value n means two to the power n time units.
// RULE10: One delay count serves as run-on time and restart interval.
// RULE11: Fault threshold is a 16-bit linear-format value in volts.
// RULE12: Action bits 7:6, retry bits 5:3, delay bits 2:0.
// RULE13: Input above threshold declares a fault and starts the response.
package frr_pkg;
	localparam logic [7:0]  CMD_VIN_OV_THRESH   = 8'h55;
	localparam logic [7:0]  CMD_VIN_OV_ACTION   = 8'h56;
	localparam logic [15:0] THRESH_RESET        = 16'h03FF;
	localparam logic [7:0]  ACTION_RESET        = 8'h80;
	localparam int          ACT_MSB             = 7;
	localparam int          ACT_LSB             = 6;
	localparam int          RETRY_MSB           = 5;
	localparam int          RETRY_LSB           = 3;
	localparam int          DELAY_MSB           = 2;
	localparam int          DELAY_LSB           = 0;
	localparam logic [1:0]  ACT_IGNORE          = 2'h0;
	localparam logic [1:0]  ACT_RUN_ON          = 2'h1;
	localparam logic [1:0]  ACT_DISABLE_RETRY   = 2'h2;
	localparam logic [1:0]  ACT_LATCH_OFF       = 2'h3;
	localparam logic [2:0]  RETRY_NONE          = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER       = 3'h7;
	localparam int          LIN_MANT_MSB        = 10;
	localparam int          LIN_EXP_LSB         = 11;
	localparam int          FIX_FRAC            = 16;
	localparam int          FIX_W               = 44;
	localparam int          DELAY_CNT_W         = 8;

	typedef enum logic [2:0] {
		FRR_RUN,
		FRR_RUN_ON,
		FRR_WAIT,
		FRR_TRY,
		FRR_LATCH
	} frr_state_t;
endpackage

/* hw/frr_delay_timer.sv */
// Delay timer counting time-unit ticks up to a power-of-two target
module frr_delay_timer #(
	parameter int CNT_W = frr_pkg::DELAY_CNT_W
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_b_i,
	// Control
	input  wire logic             start_i,
	input  wire logic             tick_i,
	input  wire logic [2:0]       sel_i,
	// Result
	output logic                  done_o
);
	logic [CNT_W-1:0] count;
	logic             running;
	logic [CNT_W:0]   target;
	logic [CNT_W:0]   count_inc;

	assign target    = (CNT_W+1)'(1) << sel_i; // [RULE9]
	assign count_inc = {1'b0, count} + (CNT_W+1)'(1);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count   <= '0;
			running <= 1'b0;
			done_o  <= 1'b0;
		end else if (start_i) begin
			count   <= '0;
			running <= 1'b1;
			done_o  <= 1'b0;
		end else if (running && tick_i) begin
			// Done holds until the next start; >= survives a shrunk target
			if (count_inc >= target) begin
				running <= 1'b0;
				done_o  <= 1'b1;
			end
			count <= count_inc[CNT_W-1:0];
		end
	end
endmodule // frr_delay_timer

/* verification/frr_monitor.sv */
// Checker for the fault response ports
module frr_monitor (
	// Clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_b_i,
	// Command port
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_cmd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_hit_o,
	// Control and status
	input wire logic        ctrl_pin_i,
	input wire logic        op_on_i,
	input wire logic        other_fault_off_i,
	input wire logic        clear_faults_i,
	input wire logic        status_clear_i,
	input wire logic        output_en_o,
	input wire logic        vin_ov_status_o,
	input wire logic        retry_latched_o,
	input wire logic [2:0]  attempt_count_o
);
	logic [7:0] act;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Shadow of the response setting
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			act <= frr_pkg::ACTION_RESET;
		else if (reg_wr_i && reg_cmd_i == frr_pkg::CMD_VIN_OV_ACTION)
			act <= reg_wdata_i[7:0];
	end
	sequence s_on;
		(ctrl_pin_i && op_on_i && !other_fault_off_i)[*3];
	endsequence
	sequence s_wr_rd;
		reg_wr_i && reg_cmd_i == frr_pkg::CMD_VIN_OV_ACTION ##1 !reg_wr_i ##1
		reg_rd_i && reg_cmd_i == frr_pkg::CMD_VIN_OV_ACTION;
	endsequence
	sequence s_pins_on;
		(ctrl_pin_i && op_on_i)[*3];
	endsequence
	property p_unmapped;
		reg_rd_i && reg_cmd_i != 8'h55 && reg_cmd_i != 8'h56
		|=> reg_rdata_o == 16'h0000 && !reg_hit_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad miss");
	property p_wr_rd;
		s_wr_rd |=> reg_hit_o &&
			reg_rdata_o == {8'h00, $past(reg_wdata_i[7:0], 3)};
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("bad readback");
	property p_ignore;
		s_on ##0 (act[7:6] == 2'h0 && output_en_o) |=> output_en_o;
	endproperty
	a_ignore: assert property (p_ignore) else $error("output lost");
	property p_run_on;
		act[7:6] == 2'h1 && $rose(vin_ov_status_o) && output_en_o |=> output_en_o;
	endproperty
	a_run_on: assert property (p_run_on) else $error("run-on cut");
	property p_disable;
		$rose(vin_ov_status_o) && act[7] |=> !output_en_o;
	endproperty
	a_disable: assert property (p_disable) else $error("not off");
	property p_latched;
		retry_latched_o |-> !output_en_o;
	endproperty
	a_latched: assert property (p_latched) else $error("on latched");
	property p_limit;
		act[5:3] != 3'h7 |-> attempt_count_o <= act[5:3];
	endproperty
	a_limit: assert property (p_limit) else $error("extra tries");
	property p_sticky;
		vin_ov_status_o && !clear_faults_i && !status_clear_i |=> vin_ov_status_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("status lost");
	property p_other_off;
		s_pins_on ##0 other_fault_off_i |=> retry_latched_o && !output_en_o;
	endproperty
	a_other_off: assert property (p_other_off) else $error("not shut");
endmodule // frr_monitor

bind frr_fault_response frr_monitor frr_monitor_i (.sys_clk_i, .rst_b_i,
	.reg_wr_i, .reg_rd_i, .reg_cmd_i, .reg_wdata_i, .reg_rdata_o, .reg_hit_o,
	.ctrl_pin_i, .op_on_i, .other_fault_off_i, .clear_faults_i,
	.status_clear_i, .output_en_o, .vin_ov_status_o, .retry_latched_o,
	.attempt_count_o);

/* verification/frr_host_model.sv */
// Host model issuing register commands
module frr_host_model (
	// Clock
	input  wire logic  clk_i,
	// Command port
	output logic        wr_o,
	output logic        rd_o,
	output logic [7:0]  cmd_o,
	output logic [15:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// One strobe cycle, then scrambled idle values
	task automatic access(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		@(negedge clk_i);
		wr_o = w;
		rd_o = !w;
		cmd_o = c;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = ~c;
		wdata_o = ~d;
	endtask
endmodule // frr_host_model

/* verification/tb.sv */
// Testbench for the fault response block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i, reg_rd_i, reg_hit_o;
	logic [7:0] reg_cmd_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, vin_meas_i = 16'h0028;
	logic time_unit_tick_i = 1'b0, clear_faults_i = 1'b0, ctrl_pin_i = 1'b1;
	logic op_on_i = 1'b1, status_clear_i = 1'b0, output_en_o;
	logic other_fault_off_i = 1'b0;
	logic vin_ov_status_o, retry_latched_o;
	logic [2:0] attempt_count_o;
	logic [1:0] tdiv = 2'h0;
	int num_errors = 0;
	int n_tests = 0;
	time t0;
	always #50 sys_clk_i = ~sys_clk_i;
	// One time unit every four clocks
	always @(negedge sys_clk_i) begin
		tdiv <= tdiv + 2'h1;
		time_unit_tick_i <= (tdiv == 2'h3);
	end
	frr_host_model frr_host_model_i (.clk_i(sys_clk_i), .wr_o(reg_wr_i),
		.rd_o(reg_rd_i), .cmd_o(reg_cmd_i), .wdata_o(reg_wdata_i));
	frr_fault_response frr_fault_response_i (.sys_clk_i, .rst_b_i,
		.reg_wr_i, .reg_rd_i, .reg_cmd_i, .reg_wdata_i, .reg_rdata_o,
		.reg_hit_o, .vin_meas_i, .time_unit_tick_i, .clear_faults_i,
		.status_clear_i, .ctrl_pin_i, .op_on_i, .other_fault_off_i,
		.output_en_o, .vin_ov_status_o, .retry_latched_o, .attempt_count_o);
	task automatic conclude();
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] c, input logic [15:0] e,
		input logic h);
		frr_host_model_i.access(1'b0, c, 16'h0000);
		chk(reg_rdata_o, e);
		chk({15'h0000, reg_hit_o}, {15'h0000, h});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic clr();
		// Let the registered compare drop first, a live fault beats a clear
		cyc(2);
		clear_faults_i = 1'b1;
		cyc(1);
		clear_faults_i = 1'b0;
	endtask
	task automatic wait_en(input logic v);
		int i;
		for (i = 0; i < 200 && output_en_o !== v; i++)
			@(negedge sys_clk_i);
		if (output_en_o !== v) begin
			num_errors++;
			conclude();
		end
	endtask
	initial begin
		cyc(16);
		rst_b_i = 1'b1;
		rdc(8'h55, 16'h03FF, 1'b1);
		rdc(8'h56, 16'h0080, 1'b1);
		rdc(8'h57, 16'h0000, 1'b0);
		frr_host_model_i.access(1'b1, 8'h55, 16'h0030);
		rdc(8'h55, 16'h0030, 1'b1);
		wait_en(1'b1);
		// Ignore
		frr_host_model_i.access(1'b1, 8'h56, 16'h0000);
		vin_meas_i = 16'h0038;
		cyc(20);
		chk({14'h0000, output_en_o, vin_ov_status_o}, 16'h0003);
		vin_meas_i = 16'h0028;
		clr();
		cyc(2);
		chk({15'h0000, vin_ov_status_o}, 16'h0000);
		// Latch off until cleared
		frr_host_model_i.access(1'b1, 8'h56, 16'h00C0);
		vin_meas_i = 16'h0038;
		wait_en(1'b0);
		vin_meas_i = 16'h0028;
		cyc(40);
		chk({15'h0000, output_en_o}, 16'h0000);
		status_clear_i = 1'b1;
		cyc(1);
		status_clear_i = 1'b0;
		wait_en(1'b1);
		// Disable, no retry
		frr_host_model_i.access(1'b1, 8'h56, 16'h0080);
		vin_meas_i = 16'h0038;
		wait_en(1'b0);
		cyc(40);
		chk({12'h000, retry_latched_o, attempt_count_o}, 16'h0008);
		vin_meas_i = 16'h0028;
		clr();
		wait_en(1'b1);
		// Two retries, two units apart
		rdc(8'h56, 16'h0080, 1'b1);
		frr_host_model_i.access(1'b1, 8'h56, 16'h0091);
		rdc(8'h56, 16'h0091, 1'b1);
		vin_meas_i = 16'h0038;
		wait_en(1'b0);
		wait_en(1'b1);
		t0 = $time;
		wait_en(1'b0);
		wait_en(1'b1);
		chk(16'(($time - t0) / 100), 16'h0008);
		cyc(40);
		chk({12'h000, retry_latched_o, attempt_count_o}, 16'h000A);
		vin_meas_i = 16'h0028;
		clr();
		wait_en(1'b1);
		// Run on for four units
		frr_host_model_i.access(1'b1, 8'h56, 16'h0052);
		vin_meas_i = 16'h0038;
		cyc(12);
		chk({15'h0000, output_en_o}, 16'h0001);
		wait_en(1'b0);
		vin_meas_i = 16'h0028;
		wait_en(1'b1);
		// Endless retries until another fault, then commanded off
		frr_host_model_i.access(1'b1, 8'h56, 16'h00B8);
		vin_meas_i = 16'h0038;
		cyc(100);
		chk({15'h0000, retry_latched_o}, 16'h0000);
		wait_en(1'b1);
		other_fault_off_i = 1'b1;
		cyc(3);
		chk({14'h0000, retry_latched_o, output_en_o}, 16'h0002);
		other_fault_off_i = 1'b0;
		op_on_i = 1'b0;
		cyc(5);
		chk({12'h000, output_en_o, attempt_count_o}, 16'h0000);
		vin_meas_i = 16'h0028;
		op_on_i = 1'b1;
		wait_en(1'b1);
		conclude();
	end
endmodule // tb
